// ---- pfr_map.svh ----
// Constants of the power-fail and recovery sequencer.
// Assumes a 40 MHz clock; included by bare name.
`ifndef PFR_MAP_SVH
`define PFR_MAP_SVH

`define PFR_CLK_NS       25
`define PFR_HOLDUP_NS    2000000
`define PFR_HOLDUP_CYC   (`PFR_HOLDUP_NS / `PFR_CLK_NS)

`define PFR_STATUS_LW_INIT 32'h041F_0000
`define PFR_PRIO_LSB       16
`define PFR_PRIO_MSB       20
`define PFR_AST_INIT       3'h4
`define PFR_CON_TX_INIT    16'h0080
`define PFR_ACCEL_NONE     32'h0000_0000
`define PFR_ACCEL_FPA      32'h0000_8001
`define PFR_ICLK_RUN       0
`define PFR_ICLK_IE        6
`define PFR_HALT_PWRUP     8'h03
`define PFR_TOD_CLR        32'h0000_0000

`define PFR_PIN_PWR      0
`define PFR_PIN_LOCK     1
`define PFR_PIN_AUTO     2
`define PFR_PIN_BATT     3

`define PFR_A_STATUS     4'h0
`define PFR_A_STAT_LW    4'h1
`define PFR_A_PRIO       4'h2
`define PFR_A_AST        4'h3
`define PFR_A_SOFT_IRQ   4'h4
`define PFR_A_ICLK       4'h5
`define PFR_A_CON_RX     4'h6
`define PFR_A_CON_TX     4'h7
`define PFR_A_MAP_EN     4'h8
`define PFR_A_PERF_EN    4'h9
`define PFR_A_ACCEL      4'hA
`define PFR_A_TOD        4'hB
`define PFR_A_HALT       4'hC

`endif

// ---- pfr_pkg.sv ----
// Types of the power-fail and recovery sequencer.
// Assumes pfr_map.svh supplies the numeric constants.
package pfr_pkg;

    typedef enum logic [2:0] {
        MJ_OFF,
        MJ_HALTED,
        MJ_BOOTING,
        MJ_RESTARTING,
        MJ_RUNNING
    } pfr_major_t;

    typedef enum logic [3:0] {
        ST_OFF,
        ST_CON_INIT,
        ST_CPU_INIT,
        ST_SAMPLE,
        ST_HALTED,
        ST_BOOTING,
        ST_RESTARTING,
        ST_RUNNING,
        ST_HOLDUP,
        ST_PF_HALT
    } pfr_fsm_t;

    typedef struct packed {
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic [3:0]  s3;
        logic [3:0]  pin;
        pfr_fsm_t    state;
        pfr_major_t  major;
        logic [23:0] timer;
        logic        lock_seen;
        logic        boot_ip;
        logic        rst_ip;
        logic        need_init;
        logic        mem_kept;
        logic        irq;
        logic        con_init_p;
        logic        cpu_init_p;
        logic        bus_init_p;
        logic        flush_p;
        logic [31:0] processor_status_longword;
        logic [2:0]  async_trap_level;
        logic [15:0] soft_irq_summary;
        logic [31:0] interval_clock_ctl;
        logic [15:0] console_rx_status;
        logic [15:0] console_tx_status;
        logic        memory_map_enable;
        logic        perf_monitor_enable;
        logic [31:0] accelerator_ctl_status;
        logic [31:0] time_of_day_reg;
        logic [7:0]  halt_code;
        logic [31:0] rdata;
    } pfr_state_t;

endpackage : pfr_pkg

// ---- pfr_top.sv ----
// Power-fail and recovery sequencer with processor register initialization.
// Assumes pins from outside the clock domain and same-clock one-cycle command pulses.
// Function
// - Raise power-fail interrupt when power fails
// - Halt, then power off after hold-up
// - Power-up: console init, cpu init, sample
// - Locked: restart first, boot if it fails
// - Unlocked: auto-restart switch alone decides
// - Halt before power loss is forgotten
// - Console init command initializes processor
// - Bus_recover_cmd command pulses system bus init
// - Power restore runs full power-up init; a restore during hold-up is ignored and it stays off
// - No run after error halt without init
// - Init sets status, level, trap, console values
// - Init clears interval clock bits 6, 0
// - Accelerator control zero or 8001 hex
// - Unlisted registers left unpredictable
// - Init leaves clock, halt code, flags
// - Init empties caches and buffers
// - Power-up clears flags, halt code 03
// - Memory kept only under battery backup
// - Time of day kept or zeroed
// - Transitions from state plus listed inputs
// - Attempt with flag already set fails
`include "pfr_map.svh"

module pfr_top #(
    parameter int HOLDUP_CYC = `PFR_HOLDUP_CYC,
    parameter bit FPA_PRESENT = 1'b0
) (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic               power_ok_pin,
    input  wire logic               lock_sw_pin,
    input  wire logic               autorestart_sw_pin,
    input  wire logic               battery_ok_pin,
    input  wire logic               powerfail_ack,
    input  wire logic               halt_instr,
    input  wire logic               error_halt,
    input  wire logic               console_init_cmd,
    input  wire logic               bus_recover_cmd,
    input  wire logic               console_continue,
    input  wire logic               attempt_ok,
    input  wire logic               attempt_fail,
    input  wire logic               os_boot_done,
    input  wire logic               os_restart_done,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    output logic                    powerfail_irq,
    output pfr_pkg::pfr_major_t     major_state,
    output logic                    console_init_pulse,
    output logic                    cpu_init_pulse,
    output logic                    bus_init_pulse,
    output logic                    buffer_flush_pulse,
    output logic                    mem_preserved
);

    pfr_pkg::pfr_state_t q;
    pfr_pkg::pfr_state_t n;
    logic                pwr_fall;
    logic                pwr_rise;

    // Processor initialization; everything not named here is left as it stood
    function automatic pfr_pkg::pfr_state_t cpu_init(input pfr_pkg::pfr_state_t s);
        pfr_pkg::pfr_state_t r;
        r = s;
        r.processor_status_longword = `PFR_STATUS_LW_INIT;
        r.async_trap_level          = `PFR_AST_INIT;
        r.soft_irq_summary          = 16'h0000;
        r.console_rx_status         = 16'h0000;
        r.console_tx_status         = `PFR_CON_TX_INIT;
        r.memory_map_enable         = 1'b0;
        r.perf_monitor_enable       = 1'b0;
        r.interval_clock_ctl[`PFR_ICLK_IE]  = 1'b0;
        r.interval_clock_ctl[`PFR_ICLK_RUN] = 1'b0;
        r.accelerator_ctl_status = FPA_PRESENT ? `PFR_ACCEL_FPA : `PFR_ACCEL_NONE;
        r.flush_p    = 1'b1;
        r.cpu_init_p = 1'b1;
        r.need_init  = 1'b0;
        // time of day, halt code, flags untouched; others too
        return r;
    endfunction : cpu_init

    function automatic pfr_pkg::pfr_major_t major_of(input pfr_pkg::pfr_fsm_t s);
        unique case (s)
            pfr_pkg::ST_OFF:        return pfr_pkg::MJ_OFF;
            pfr_pkg::ST_BOOTING:    return pfr_pkg::MJ_BOOTING;
            pfr_pkg::ST_RESTARTING: return pfr_pkg::MJ_RESTARTING;
            pfr_pkg::ST_RUNNING,
            pfr_pkg::ST_HOLDUP:     return pfr_pkg::MJ_RUNNING;
            pfr_pkg::ST_CON_INIT,
            pfr_pkg::ST_CPU_INIT,
            pfr_pkg::ST_SAMPLE,
            pfr_pkg::ST_HALTED,
            pfr_pkg::ST_PF_HALT:    return pfr_pkg::MJ_HALTED;
        endcase
    endfunction : major_of

    always_comb begin
        n = q;
        n.con_init_p = 1'b0;
        n.cpu_init_p = 1'b0;
        n.bus_init_p = 1'b0;
        n.flush_p    = 1'b0;
        n.rdata      = 32'h0000_0000;

        // Three-stage pin filter: a change counts once stages two and three agree
        n.s1 = {battery_ok_pin, autorestart_sw_pin, lock_sw_pin, power_ok_pin};
        n.s2 = q.s1;
        n.s3 = q.s2;
        for (int i = 0; i < 4; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                n.pin[i] = q.s3[i];
            end
        end
        pwr_fall = q.pin[`PFR_PIN_PWR] && !n.pin[`PFR_PIN_PWR];
        pwr_rise = !q.pin[`PFR_PIN_PWR] && n.pin[`PFR_PIN_PWR];

        // Flags cleared by the running system; a same-cycle set below wins
        if (os_boot_done) begin
            n.boot_ip = 1'b0;
        end
        if (os_restart_done) begin
            n.rst_ip = 1'b0;
        end
        if (powerfail_ack) begin
            n.irq = 1'b0;
        end

        // Register writes; hardware events later in this process take priority
        if (reg_wr) begin
            unique case (reg_addr)
                `PFR_A_STAT_LW:  n.processor_status_longword = reg_wdata;
                `PFR_A_PRIO:     n.processor_status_longword[`PFR_PRIO_MSB:`PFR_PRIO_LSB] =
                                     reg_wdata[4:0];
                `PFR_A_AST:      n.async_trap_level = reg_wdata[2:0];
                `PFR_A_SOFT_IRQ: n.soft_irq_summary = reg_wdata[15:0];
                `PFR_A_ICLK:     n.interval_clock_ctl = reg_wdata;
                `PFR_A_CON_RX:   n.console_rx_status = reg_wdata[15:0];
                `PFR_A_CON_TX:   n.console_tx_status = reg_wdata[15:0];
                `PFR_A_MAP_EN:   n.memory_map_enable = reg_wdata[0];
                `PFR_A_PERF_EN:  n.perf_monitor_enable = reg_wdata[0];
                `PFR_A_ACCEL:    n.accelerator_ctl_status = reg_wdata;
                `PFR_A_TOD:      n.time_of_day_reg = reg_wdata;
                `PFR_A_HALT:     n.halt_code = reg_wdata[7:0];
                default:         n.rdata = 32'h0000_0000;
            endcase
        end

        if (bus_recover_cmd && q.state != pfr_pkg::ST_OFF) begin
            n.bus_init_p = 1'b1;
        end
        if (console_init_cmd && q.state != pfr_pkg::ST_OFF) begin
            n = cpu_init(n);
        end

        unique case (q.state)
            pfr_pkg::ST_OFF: begin
                // only the interrupt is cleared; registers keep their old contents
                n.irq = 1'b0;
                if (pwr_rise) begin
                    n.state      = pfr_pkg::ST_CON_INIT;
                    n.con_init_p = 1'b1;
                end
            end
            pfr_pkg::ST_CON_INIT: begin
                n.state = pfr_pkg::ST_CPU_INIT;
            end
            pfr_pkg::ST_CPU_INIT: begin
                n = cpu_init(n);
                n.boot_ip   = 1'b0;
                n.rst_ip    = 1'b0;
                n.halt_code = `PFR_HALT_PWRUP;
                n.mem_kept  = q.pin[`PFR_PIN_BATT];
                // time of day kept or zeroed
                if (!q.pin[`PFR_PIN_BATT]) begin
                    n.time_of_day_reg = `PFR_TOD_CLR;
                end
                n.state = pfr_pkg::ST_SAMPLE;
            end
            pfr_pkg::ST_SAMPLE: begin
                n.lock_seen = q.pin[`PFR_PIN_LOCK];
                if (q.pin[`PFR_PIN_LOCK] || q.pin[`PFR_PIN_AUTO]) begin
                    n.state = pfr_pkg::ST_RESTARTING;
                    n.rst_ip = 1'b1;
                end else begin
                    n.state = pfr_pkg::ST_HALTED;
                end
            end
            pfr_pkg::ST_RESTARTING: begin
                if (attempt_ok) begin
                    n.state = pfr_pkg::ST_RUNNING;
                end else if (attempt_fail) begin
                    if (q.lock_seen && !q.boot_ip) begin
                        n.state   = pfr_pkg::ST_BOOTING;
                        n.boot_ip = 1'b1;
                    end else begin
                        n.state = pfr_pkg::ST_HALTED;
                    end
                end
            end
            pfr_pkg::ST_BOOTING: begin
                if (attempt_ok) begin
                    n.state = pfr_pkg::ST_RUNNING;
                end else if (attempt_fail) begin
                    n.state = pfr_pkg::ST_HALTED;
                end
            end
            pfr_pkg::ST_HALTED: begin
                // run needs init after error halt
                if (console_continue && !q.need_init && !console_init_cmd) begin
                    n.state = pfr_pkg::ST_RUNNING;
                end
            end
            pfr_pkg::ST_RUNNING: begin
                if (error_halt) begin
                    n.state     = pfr_pkg::ST_HALTED;
                    n.need_init = 1'b1;
                end else if (halt_instr) begin
                    n.state = pfr_pkg::ST_HALTED;
                end
            end
            pfr_pkg::ST_HOLDUP: begin
                if (q.timer == 24'(HOLDUP_CYC - 1)) begin
                    n.state = pfr_pkg::ST_PF_HALT;
                end else begin
                    n.timer = q.timer + 24'h00_0001;
                end
            end
            pfr_pkg::ST_PF_HALT: begin
                n.state = pfr_pkg::ST_OFF;
                n.irq   = 1'b0;
            end
        endcase

        // Power loss overrides any state except off and the shutdown tail itself
        if (pwr_fall && q.state != pfr_pkg::ST_OFF && q.state != pfr_pkg::ST_HOLDUP
            && q.state != pfr_pkg::ST_PF_HALT) begin
            n.irq   = 1'b1;
            n.state = pfr_pkg::ST_HOLDUP;
            n.timer = 24'h00_0000;
        end
        n.major = major_of(n.state);

        if (reg_rd) begin
            unique case (reg_addr)
                `PFR_A_STATUS: n.rdata = {16'h0000, 4'(q.state), 5'h00, q.mem_kept,
                                          q.need_init, q.lock_seen, q.irq,
                                          q.rst_ip, q.boot_ip, 1'b0};
                `PFR_A_STAT_LW:  n.rdata = q.processor_status_longword;
                `PFR_A_PRIO:     n.rdata = {27'h000_0000,
                    q.processor_status_longword[`PFR_PRIO_MSB:`PFR_PRIO_LSB]};
                `PFR_A_AST:      n.rdata = {29'h0000_0000, q.async_trap_level};
                `PFR_A_SOFT_IRQ: n.rdata = {16'h0000, q.soft_irq_summary};
                `PFR_A_ICLK:     n.rdata = q.interval_clock_ctl;
                `PFR_A_CON_RX:   n.rdata = {16'h0000, q.console_rx_status};
                `PFR_A_CON_TX:   n.rdata = {16'h0000, q.console_tx_status};
                `PFR_A_MAP_EN:   n.rdata = {31'h0000_0000, q.memory_map_enable};
                `PFR_A_PERF_EN:  n.rdata = {31'h0000_0000, q.perf_monitor_enable};
                `PFR_A_ACCEL:    n.rdata = q.accelerator_ctl_status;
                `PFR_A_TOD:      n.rdata = q.time_of_day_reg;
                `PFR_A_HALT:   n.rdata = {24'h00_0000, q.halt_code};
                default:       n.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q       <= '0;
            q.state <= pfr_pkg::ST_OFF;
            q.major <= pfr_pkg::MJ_OFF;
        end else if (ce) begin
            q <= n;
        end
    end

    assign reg_rdata          = q.rdata;
    assign powerfail_irq      = q.irq;
    assign major_state        = q.major;
    assign console_init_pulse = q.con_init_p;
    assign cpu_init_pulse     = q.cpu_init_p;
    assign bus_init_pulse     = q.bus_init_p;
    assign buffer_flush_pulse = q.flush_p;
    assign mem_preserved      = q.mem_kept;

    // Checks assume ce held high; frozen cycles are not judged
    default clocking @(posedge clock); endclocking
    default disable iff (rst || !ce);

    irq_raise_a: assert property (
        (pwr_fall && q.state == pfr_pkg::ST_RUNNING) |=> powerfail_irq
            && q.state == pfr_pkg::ST_HOLDUP)
        else $error("power fail did not raise interrupt");

    irq_hold_a: assert property (
        (q.irq && !powerfail_ack && q.state == pfr_pkg::ST_HOLDUP) |=> q.irq)
        else $error("interrupt dropped without acknowledge");

    pf_halt_off_a: assert property (
        (q.state == pfr_pkg::ST_PF_HALT) |=> (q.state == pfr_pkg::ST_OFF && !q.irq))
        else $error("halt did not lead to power off");

    pwrup_order_a: assert property (
        (q.state == pfr_pkg::ST_OFF && pwr_rise) |=> console_init_pulse
            ##2 cpu_init_pulse && q.state == pfr_pkg::ST_SAMPLE)
        else $error("power-up order wrong");

    init_values_a: assert property (
        cpu_init_pulse |-> (q.processor_status_longword == `PFR_STATUS_LW_INIT
            && q.async_trap_level == `PFR_AST_INIT && q.console_tx_status == `PFR_CON_TX_INIT
            && q.soft_irq_summary == 16'h0000 && q.console_rx_status == 16'h0000
            && !q.memory_map_enable && !q.perf_monitor_enable
            && q.processor_status_longword[`PFR_PRIO_MSB:`PFR_PRIO_LSB] == 5'h1F))
        else $error("init values wrong");

    iclk_clear_a: assert property (
        cpu_init_pulse |-> !q.interval_clock_ctl[`PFR_ICLK_IE]
            && !q.interval_clock_ctl[`PFR_ICLK_RUN] && buffer_flush_pulse)
        else $error("clock control bits not cleared");

    accel_value_a: assert property (
        cpu_init_pulse |-> q.accelerator_ctl_status
            == (FPA_PRESENT ? `PFR_ACCEL_FPA : `PFR_ACCEL_NONE))
        else $error("accelerator control wrong");

    pwrup_flags_a: assert property (
        (q.state == pfr_pkg::ST_SAMPLE) |-> (!q.boot_ip && !q.rst_ip
            && q.halt_code == `PFR_HALT_PWRUP))
        else $error("power-up flags wrong");

    lock_restart_a: assert property (
        (q.state == pfr_pkg::ST_SAMPLE && q.pin[`PFR_PIN_LOCK] && !pwr_fall)
            |=> q.state == pfr_pkg::ST_RESTARTING && q.rst_ip)
        else $error("locked power-up did not restart");

    tod_zero_a: assert property (
        (q.state == pfr_pkg::ST_SAMPLE && !q.mem_kept) |-> q.time_of_day_reg == `PFR_TOD_CLR)
        else $error("time of day not cleared");

    no_run_a: assert property (
        (q.state == pfr_pkg::ST_HALTED && q.need_init) |=> q.state != pfr_pkg::ST_RUNNING)
        else $error("ran after error halt without init");

    holdup_c: cover property (q.state == pfr_pkg::ST_HOLDUP ##1 q.state == pfr_pkg::ST_PF_HALT);
    lock_boot_c: cover property (q.state == pfr_pkg::ST_RESTARTING
        ##1 q.state == pfr_pkg::ST_BOOTING);
    resume_c: cover property (q.state == pfr_pkg::ST_HALTED ##1 q.state == pfr_pkg::ST_RUNNING);

endmodule : pfr_top

// ---- pfr_supply_model.sv ----
// Power supply and front-panel switch model for the sequencer bench.
// Assumes the bench steers mains and switch settings on the core clock.
module pfr_supply_model #(
    parameter int HOLD_CYC = 22
) (
    input  wire logic clock,
    input  wire logic want_power,
    input  wire logic lock_cfg,
    input  wire logic auto_cfg,
    input  wire logic batt_cfg,
    input  wire logic powerfail_irq,
    output wire logic power_ok_pin,
    output wire logic lock_sw_pin,
    output wire logic autorestart_sw_pin,
    output wire logic battery_ok_pin,
    output wire logic rail_on
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold_left = 0;
    // Pins are asynchronous to the core, so they move off the edge
    assign #3 power_ok_pin       = want_power;
    assign #3 lock_sw_pin        = lock_cfg;
    assign #3 autorestart_sw_pin = auto_cfg;
    assign #3 battery_ok_pin     = batt_cfg;
    always @(posedge clock) begin
        if (want_power) begin
            hold_left <= HOLD_CYC;
        end else if (hold_left > 0 && (powerfail_irq || hold_left < HOLD_CYC)) begin
            hold_left <= hold_left - 1;
        end
    end
    // Rail drops only once mains and the reserve are both gone
    assign rail_on = want_power || hold_left > 0;
endmodule : pfr_supply_model

// ---- test_powerfail_recovery_init.sv ----
// Self-checking bench for the power-fail and recovery sequencer.
// Assumes pfr_top with a shortened hold-up and the supply model beside it.
module test_powerfail_recovery_init;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 20;
    localparam int ACK = 0, HALT = 1, ERR = 2, INIT = 3, BUS = 4, CONT = 5, OK = 6, FAIL = 7;
    localparam int BDN = 8, RDN = 9;
    logic        clock, rst, ce, want_power, lock_cfg, auto_cfg, batt_cfg, rail_on;
    logic        power_ok_pin, lock_sw_pin, autorestart_sw_pin, battery_ok_pin;
    logic        reg_wr, reg_rd, powerfail_irq, mem_preserved;
    logic        console_init_pulse, cpu_init_pulse, bus_init_pulse, buffer_flush_pulse;
    logic [9:0]  cmd;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [31:0] m [16];
    logic [31:0] msk [16] = '{32'h0, 32'h0, 32'h0, 32'h7, 32'hFFFF, 32'hFFFF_FFFF, 32'hFFFF,
        32'hFFFF, 32'h1, 32'h1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFF, 32'h0, 32'h0, 32'h0};
    logic [31:0] ini [11] = '{32'h0, 32'h041F_0000, 32'h1F, 32'h4, 32'h0, 32'h0, 32'h0,
        32'h80, 32'h0, 32'h0, 32'h8001};
    pfr_pkg::pfr_major_t major_state;
    wire  [3:0]  obs = {major_state == pfr_pkg::MJ_OFF, cpu_init_pulse, console_init_pulse,
        powerfail_irq};
    int          n_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;

    pfr_top #(.HOLDUP_CYC(HOLD), .FPA_PRESENT(1'b1)) u_dut (
        .clock, .rst, .ce, .power_ok_pin, .lock_sw_pin, .autorestart_sw_pin,
        .battery_ok_pin, .powerfail_ack(cmd[ACK]), .halt_instr(cmd[HALT]),
        .error_halt(cmd[ERR]), .console_init_cmd(cmd[INIT]), .bus_recover_cmd(cmd[BUS]),
        .console_continue(cmd[CONT]), .attempt_ok(cmd[OK]), .attempt_fail(cmd[FAIL]),
        .os_boot_done(cmd[BDN]), .os_restart_done(cmd[RDN]), .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .powerfail_irq, .major_state, .console_init_pulse,
        .cpu_init_pulse, .bus_init_pulse, .buffer_flush_pulse, .mem_preserved
    );

    pfr_supply_model #(.HOLD_CYC(HOLD + 2)) u_supply (
        .clock, .want_power, .lock_cfg, .auto_cfg, .batt_cfg, .powerfail_irq,
        .power_ok_pin, .lock_sw_pin, .autorestart_sw_pin, .battery_ok_pin, .rail_on
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic end_of_test();
        $display("checks_done %0d n_errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // A hang anywhere ends the run as a failure
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic void cpu_init();
        for (int i = 1; i < 11; i++) if (i != 5) m[i] = ini[i];
        m[5] = m[5] & 32'hFFFF_FFBE;
    endfunction : cpu_init

    task automatic wt(input int k);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (obs[k] !== 1'b1 && n < 4 * HOLD);
    endtask : wt

    task automatic wr(input int a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= 4'(a);
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        m[a] = d & msk[a];
    endtask : wr

    task automatic rd(input int a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= 4'(a);
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk(reg_rdata, m[a]);
    endtask : rd

    task automatic rd_all();
        for (int a = 1; a < 15; a++) rd(a);
    endtask : rd_all

    task automatic step(input int b, input pfr_pkg::pfr_major_t e);
        @(posedge clock);
        cmd[b] <= 1'b1;
        @(posedge clock);
        cmd <= '0;
        @(negedge clock);
        chk(major_state, e);
    endtask : step

    task automatic up(input bit l, input bit a, input bit b);
        int t0;
        wt(1);
        t0 = cyc;
        wt(2);
        chk(cyc - t0, 2);
        chk(buffer_flush_pulse, 1);
        chk(mem_preserved, b);
        cpu_init();
        m[12] = 32'h3;
        if (!b) m[11] = 32'h0;
        @(negedge clock);
        chk(major_state, (l || a) ? pfr_pkg::MJ_RESTARTING : pfr_pkg::MJ_HALTED);
        rd_all();
    endtask : up

    task automatic cycle(input bit l, input bit a, input bit b, input bit ack);
        int t0;
        @(posedge clock);
        lock_cfg <= l;
        auto_cfg <= a;
        batt_cfg <= b;
        want_power <= 1'b0;
        wt(0);
        t0 = cyc;
        chk(powerfail_irq, 1);
        if (ack) begin
            @(posedge clock);
            cmd[ACK] <= 1'b1;
            @(posedge clock);
            cmd[ACK] <= 1'b0;
            @(negedge clock);
            chk(powerfail_irq, 0);
        end
        wt(3);
        chk(cyc - t0, HOLD + 1);
        chk(powerfail_irq, 0);
        chk(rail_on, 1);
        @(posedge clock);
        want_power <= 1'b1;
        up(l, a, b);
    endtask : cycle

    initial begin
        void'($urandom(2115));
        rst = 1'b1;
        ce = 1'b1;
        want_power = 1'b1;
        {lock_cfg, auto_cfg, batt_cfg, reg_wr, reg_rd} = '0;
        cmd = '0;
        reg_addr = '0;
        reg_wdata = '0;
        foreach (m[i]) m[i] = '0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        up(0, 0, 0);
        // Every switch pairing, with random contents that power-up must sort out
        for (int i = 0; i < 4; i++) begin
            for (int a = 3; a < 15; a++) wr(a, $urandom);
            rd_all();
            cycle(i[1], i[0], 1'($urandom), i == 1);
            if (i == 1) step(FAIL, pfr_pkg::MJ_HALTED);
        end
        step(FAIL, pfr_pkg::MJ_BOOTING);
        step(OK, pfr_pkg::MJ_RUNNING);
        step(HALT, pfr_pkg::MJ_HALTED);
        step(CONT, pfr_pkg::MJ_RUNNING);
        step(ERR, pfr_pkg::MJ_HALTED);
        step(CONT, pfr_pkg::MJ_HALTED);
        step(INIT, pfr_pkg::MJ_HALTED);
        chk(cpu_init_pulse, 1);
        cpu_init();
        rd_all();
        step(CONT, pfr_pkg::MJ_RUNNING);
        step(BUS, pfr_pkg::MJ_RUNNING);
        chk(bus_init_pulse, 1);
        cycle(1, 0, 1, 0);
        step(FAIL, pfr_pkg::MJ_BOOTING);
        step(FAIL, pfr_pkg::MJ_HALTED);
        // progress flags stay set after failures
        m[0] = {16'h0000, 4'(pfr_pkg::ST_HALTED), 12'h056};
        rd(0);
        step(BDN, pfr_pkg::MJ_HALTED);
        step(RDN, pfr_pkg::MJ_HALTED);
        m[0] = {16'h0000, 4'(pfr_pkg::ST_HALTED), 12'h050};
        rd(0);
        // Frozen clock enable must ignore a continue
        @(posedge clock);
        ce <= 1'b0;
        step(CONT, pfr_pkg::MJ_HALTED);
        @(posedge clock);
        ce <= 1'b1;
        step(CONT, pfr_pkg::MJ_RUNNING);
        end_of_test();
    end
endmodule : test_powerfail_recovery_init
